// ---- rtl/adccsp_defs.svh ----
`ifndef ADCCSP_DEFS_SVH
`define ADCCSP_DEFS_SVH

// Master clock divide selection
`define ADCCSP_MCD_DIV1 2'h0
`define ADCCSP_MCD_DIV2 2'h1
`define ADCCSP_MCD_DIV3 2'h2

// Framing format selection
`define ADCCSP_FMT_I2S 2'h0
`define ADCCSP_FMT_LJ 2'h1
`define ADCCSP_FMT_RJ 2'h2
`define ADCCSP_FMT_DSP 2'h3

// Sample width selection and widths in bits
`define ADCCSP_WW_24 2'h0
`define ADCCSP_WW_20 2'h1
`define ADCCSP_WW_16 2'h2
`define ADCCSP_W24 6'h18
`define ADCCSP_W20 6'h14
`define ADCCSP_W16 6'h10
`define ADCCSP_SLOT_BITS 7'h20

// Input gain in Q8: 0, 3, 6, 9 and 12 dB
`define ADCCSP_GAIN_0DB 11'h100
`define ADCCSP_GAIN_3DB 11'h16a
`define ADCCSP_GAIN_6DB 11'h200
`define ADCCSP_GAIN_9DB 11'h2d4
`define ADCCSP_GAIN_12DB 11'h400

// Timing counts, all as last value of a counter
`define ADCCSP_MOD_LAST_48 2'h1
`define ADCCSP_MOD_LAST_96 2'h3
`define ADCCSP_SINC_LAST_48 4'hf
`define ADCCSP_SINC_LAST_96 4'h7
`define ADCCSP_FIR_LAST 3'h7
`define ADCCSP_BCLK_PH_LAST 2'h3
`define ADCCSP_POS_LAST 6'h3f

// Saturation bounds, negative full scale is one above the most negative code
`define ADCCSP_POS_FS 27'sh07fffff
`define ADCCSP_NEG_FS_24 27'sh7800001
`define ADCCSP_NEG_FS_20 27'sh7800010
`define ADCCSP_NEG_FS_16 27'sh7800100

// Controller register map, byte offsets
`define ADCCSP_REG_CTRL 5'h00
`define ADCCSP_REG_LEFT 5'h04
`define ADCCSP_REG_RIGHT 5'h08
`define ADCCSP_REG_STAT 5'h0c
`define ADCCSP_CTRL_MASTER 0
`define ADCCSP_CTRL_FMT_LO 1
`define ADCCSP_CTRL_WW_LO 3
`define ADCCSP_CTRL_RESET 8'h00

`endif

// ---- rtl/adccsp_pkg.sv ----
`include "adccsp_defs.svh"
package adccsp_pkg;
   typedef logic [1:0] adccsp_fmt_t;
   typedef logic [1:0] adccsp_ww_t;
   typedef logic [23:0] adccsp_smp_t;

   // Width of a sample in bits for a width selection
   function automatic logic [5:0] adccsp_width(input adccsp_ww_t ww);
      case (ww)
         `ADCCSP_WW_20: adccsp_width = `ADCCSP_W20;
         `ADCCSP_WW_16: adccsp_width = `ADCCSP_W16;
         default: adccsp_width = `ADCCSP_W24;
      endcase
   endfunction

   // Sample bit number (0 is MSB) carried in slot period s, negative or past the width if none
   function automatic logic [6:0] adccsp_bit_index(input adccsp_fmt_t f, input adccsp_ww_t ww,
                                                   input logic [4:0] s);
      logic [6:0] off;
      begin
         off = 7'h00;
         if (f == `ADCCSP_FMT_I2S) begin
            off = 7'h01; // R12
         end else if (f == `ADCCSP_FMT_RJ) begin
            off = `ADCCSP_SLOT_BITS - {1'b0, adccsp_width(ww)}; // R14 R16
         end
         adccsp_bit_index = {2'h0, s} - off; // R13 R15
      end
   endfunction

   // Index lies inside the selected width
   function automatic logic adccsp_bit_valid(input logic [6:0] k, input adccsp_ww_t ww);
      adccsp_bit_valid = !k[6] && (k[5:0] < adccsp_width(ww));
   endfunction

   // Frame clock level of the master in frame period p
   function automatic logic adccsp_lr_level(input adccsp_fmt_t f, input logic [5:0] p);
      case (f)
         `ADCCSP_FMT_I2S: adccsp_lr_level = p[5]; // R12
         `ADCCSP_FMT_DSP: adccsp_lr_level = (p == `ADCCSP_POS_LAST); // R15
         default: adccsp_lr_level = !p[5]; // R13 R14
      endcase
   endfunction

   // Left frame start seen at a rising bit clock
   function automatic logic adccsp_frame_start(input adccsp_fmt_t f, input logic prev,
                                               input logic now);
      case (f)
         `ADCCSP_FMT_I2S: adccsp_frame_start = prev && !now; // R12
         `ADCCSP_FMT_DSP: adccsp_frame_start = now; // R15
         default: adccsp_frame_start = !prev && now; // R13 R14
      endcase
   endfunction
endpackage

// ---- rtl/adccsp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface adccsp_if;
   logic bclk_dev;
   logic bclk_dev_oe_n;
   logic bclk_host;
   logic bclk_host_oe_n;
   logic lrclk_dev;
   logic lrclk_dev_oe_n;
   logic lrclk_host;
   logic lrclk_host_oe_n;
   logic serial_sample_out;
   logic bclk;
   logic lrclk;

   // Wire levels from the enables; an undriven line reads low
   assign bclk = !bclk_dev_oe_n ? bclk_dev : (!bclk_host_oe_n ? bclk_host : 1'b0);
   assign lrclk = !lrclk_dev_oe_n ? lrclk_dev : (!lrclk_host_oe_n ? lrclk_host : 1'b0);

   modport dev (output bclk_dev, bclk_dev_oe_n, lrclk_dev, lrclk_dev_oe_n, serial_sample_out,
                input bclk, lrclk);
   modport host (output bclk_host, bclk_host_oe_n, lrclk_host, lrclk_host_oe_n,
                 input bclk, lrclk, serial_sample_out);
endinterface
`default_nettype wire

// ---- rtl/adccsp_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adccsp_defs.svh"
// Notes on behaviour
// (R01) Divide master clock by 1, 2 or 3
// (R02) Divider must give internal clock of 256 fs
// (R03) Modulator clock is internal clock /2 or /4
// (R04) Sinc stage decimates by 16 or 8
// (R05) Half-band and compensation stages decimate by 8
// (R06) High-pass enable removes dc from samples
// (R07) Two's complement, negative full scale clipped up one
// (R08) Sample width 16, 20 or 24 bits
// (R09) Two-bit field selects the framing format
// (R10) Frame clock at fs, bit clock 64 fs
// (R11) Serial data changes on falling bit clock
// (R12) I2S: MSB second period, falling edge left
// (R13) Left-justified: MSB first period, rising edge left
// (R14) Right-justified: LSB in last slot period
// (R15) DSP: one-period sync pulse before the MSB
// (R16) Receiver must match width in right-justified framing
// (R17) Analog section on at reset, direct bits power down
// (R18) Five gains, 0 to 12 dB, per channel
// (R19) Master drives frame clock, slave receives it
// (R20) Unused slot periods are sent as zero
module adccsp_dev
   import adccsp_pkg::*;
#(
   parameter int HPF_SHIFT = 10
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   adccsp_if.dev link,
   input wire logic device_master_i,
   input wire logic [1:0] master_clock_divide_sel_i,
   input wire logic modulator_rate_sel_i,
   input wire logic highpass_enable_i,
   input wire logic [1:0] framing_format_sel_i,
   input wire logic [1:0] sample_width_sel_i,
   input wire logic left_modulator_direct_i,
   input wire logic right_modulator_direct_i,
   input wire logic [2:0] gain_left_i,
   input wire logic [2:0] gain_right_i,
   input wire logic [3:0] mod_left_i,
   input wire logic [3:0] mod_right_i,
   output logic analog_powered_o,
   output logic internal_master_clock_o,
   output logic modulator_clock_o,
   output logic sample_valid_o,
   output logic [23:0] left_sample_o,
   output logic [23:0] right_sample_o
);
   logic [1:0] mdiv_cnt_r;
   logic [1:0] mdiv_last;
   logic [1:0] mod_cnt_r;
   logic mod_tick_r;
   logic [3:0] sinc_cnt_r;
   logic [2:0] fir_cnt_r;
   logic sinc_wrap;
   logic fir_wrap;
   logic out_tick_r;
   logic [3:0] mod_in [2];
   logic [2:0] gain_sel [2];
   adccsp_smp_t samp_r [2];
   adccsp_smp_t tx_r [2];
   logic [1:0] bph_r;
   logic bclk_r;
   logic lrclk_r;
   logic oe_n_r;
   logic serial_sample_out_r;
   logic [5:0] pos_r;
   logic [5:0] pos_nxt;
   logic sync_seen_r;
   logic bclk_prev_r;
   logic lr_prev_r;
   logic fall;
   logic rise;
   logic [6:0] kidx;

   // Internal clock as a one-cycle pulse of the input clock
   always_comb begin
      case (master_clock_divide_sel_i)
         `ADCCSP_MCD_DIV2: mdiv_last = 2'h1;
         `ADCCSP_MCD_DIV3: mdiv_last = 2'h2;
         default: mdiv_last = 2'h0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mdiv_cnt_r <= 2'h0;
         internal_master_clock_o <= 1'b0;
      end else if (clk_en_i) begin
         if (mdiv_cnt_r >= mdiv_last) begin
            mdiv_cnt_r <= 2'h0;
            internal_master_clock_o <= 1'b1; // R01
         end else begin
            mdiv_cnt_r <= mdiv_cnt_r + 2'h1;
            internal_master_clock_o <= 1'b0;
         end
      end
   end

   // Modulator clock: square wave and a sample pulse per period
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mod_cnt_r <= 2'h0;
         mod_tick_r <= 1'b0;
         modulator_clock_o <= 1'b0;
      end else if (clk_en_i) begin
         mod_tick_r <= 1'b0;
         if (internal_master_clock_o) begin
            if (mod_cnt_r == (modulator_rate_sel_i ? `ADCCSP_MOD_LAST_96 :
               `ADCCSP_MOD_LAST_48)) begin
               mod_cnt_r <= 2'h0; // R03
               mod_tick_r <= 1'b1;
            end else begin
               mod_cnt_r <= mod_cnt_r + 2'h1;
            end
            modulator_clock_o <= modulator_rate_sel_i ? mod_cnt_r[1] : mod_cnt_r[0];
         end
      end
   end

   // Decimation counters shared by both channels
   assign sinc_wrap = mod_tick_r && (sinc_cnt_r == (modulator_rate_sel_i ?
                      `ADCCSP_SINC_LAST_96 : `ADCCSP_SINC_LAST_48)); // R04
   assign fir_wrap = sinc_wrap && (fir_cnt_r == `ADCCSP_FIR_LAST); // R05

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sinc_cnt_r <= 4'h0;
         fir_cnt_r <= 3'h0;
         out_tick_r <= 1'b0;
      end else if (clk_en_i) begin
         if (mod_tick_r) begin
            sinc_cnt_r <= sinc_wrap ? 4'h0 : sinc_cnt_r + 4'h1;
         end
         if (sinc_wrap) begin
            fir_cnt_r <= fir_wrap ? 3'h0 : fir_cnt_r + 3'h1;
         end
         out_tick_r <= fir_wrap;
      end
   end

   // Input section stays on unless both channels bypass it
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         analog_powered_o <= 1'b1; // R17
      end else if (clk_en_i) begin
         analog_powered_o <= !(left_modulator_direct_i && right_modulator_direct_i); // R17
      end
   end

   assign mod_in[0] = mod_left_i;
   assign mod_in[1] = mod_right_i;
   assign gain_sel[0] = gain_left_i;
   assign gain_sel[1] = gain_right_i;

   // Per-channel gain, decimation, dc removal and saturation
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      logic [10:0] gain;
      logic signed [15:0] prod;
      logic signed [25:0] sinc_acc_r;
      logic signed [25:0] sinc_sum;
      logic signed [25:0] sinc_val;
      logic signed [25:0] fir_acc_r;
      logic signed [26:0] dec_r;
      logic signed [26:0] dc_r;
      logic signed [26:0] hp;
      logic signed [26:0] lo;

      always_comb begin
         case (gain_sel[ch])
            3'h0: gain = `ADCCSP_GAIN_0DB; // R18
            3'h1: gain = `ADCCSP_GAIN_3DB;
            3'h2: gain = `ADCCSP_GAIN_6DB;
            3'h3: gain = `ADCCSP_GAIN_9DB;
            default: gain = `ADCCSP_GAIN_12DB;
         endcase
         if (!analog_powered_o) begin
            gain = `ADCCSP_GAIN_0DB; // R17
         end
      end

      assign prod = $signed(mod_in[ch]) * $signed({1'b0, gain});
      assign sinc_sum = sinc_acc_r + {{10{prod[15]}}, prod};
      // The shorter sinc window is doubled so both rates share one scale
      assign sinc_val = modulator_rate_sel_i ? (sinc_sum <<< 1) : sinc_sum; // R04
      assign hp = highpass_enable_i ? dec_r - dc_r : dec_r; // R06

      always_comb begin
         case (sample_width_sel_i)
            `ADCCSP_WW_20: lo = `ADCCSP_NEG_FS_20; // R07 R08
            `ADCCSP_WW_16: lo = `ADCCSP_NEG_FS_16;
            default: lo = `ADCCSP_NEG_FS_24;
         endcase
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            sinc_acc_r <= 26'sh0;
            fir_acc_r <= 26'sh0;
            dec_r <= 27'sh0;
            dc_r <= 27'sh0;
            samp_r[ch] <= 24'h0;
         end else if (clk_en_i) begin
            if (mod_tick_r) begin
               sinc_acc_r <= sinc_wrap ? 26'sh0 : sinc_sum; // R04
            end
            if (sinc_wrap) begin
               fir_acc_r <= fir_wrap ? 26'sh0 : fir_acc_r + sinc_val; // R05
            end
            if (fir_wrap) begin
               dec_r <= {fir_acc_r[25], fir_acc_r + sinc_val} <<< 2; // R05
            end
            if (out_tick_r) begin
               // First-order dc tracker; a plain shift keeps it multiplier-free
               dc_r <= highpass_enable_i ? dc_r + (hp >>> HPF_SHIFT) : 27'sh0; // R06
               if (hp > `ADCCSP_POS_FS) begin
                  samp_r[ch] <= 24'h7fffff; // R07
               end else if (hp < lo) begin
                  samp_r[ch] <= lo[23:0]; // R07
               end else begin
                  samp_r[ch] <= hp[23:0];
               end
            end
         end
      end
   end

   assign left_sample_o = samp_r[0];
   assign right_sample_o = samp_r[1];

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sample_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         sample_valid_o <= out_tick_r;
      end
   end

   // Bit clock edges: made from the internal clock as master, seen on the pin as slave
   assign fall = device_master_i ? (internal_master_clock_o && bph_r == `ADCCSP_BCLK_PH_LAST)
                                 : (bclk_prev_r && !link.bclk); // R10 R02
   assign rise = !device_master_i && !bclk_prev_r && link.bclk;
   assign pos_nxt = (!device_master_i && sync_seen_r) ?
                    ((framing_format_sel_i == `ADCCSP_FMT_DSP) ? 6'h00 : 6'h01) : pos_r + 6'h01;
   assign kidx = adccsp_bit_index(framing_format_sel_i, sample_width_sel_i, pos_nxt[4:0]); // R09

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bph_r <= 2'h0;
         bclk_r <= 1'b0;
         bclk_prev_r <= 1'b0;
         lr_prev_r <= 1'b0;
         sync_seen_r <= 1'b0;
      end else if (clk_en_i) begin
         bclk_prev_r <= link.bclk;
         if (internal_master_clock_o) begin
            bph_r <= bph_r + 2'h1;
            bclk_r <= (bph_r == 2'h1) || (bph_r == 2'h2); // R10
         end
         if (rise) begin
            lr_prev_r <= link.lrclk;
            sync_seen_r <= adccsp_frame_start(framing_format_sel_i, lr_prev_r, link.lrclk); // R19
         end else if (fall) begin
            sync_seen_r <= 1'b0;
         end
      end
   end

   // Frame position, frame clock and data all move on the falling bit clock
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pos_r <= `ADCCSP_POS_LAST;
         lrclk_r <= 1'b0;
         serial_sample_out_r <= 1'b0;
         oe_n_r <= 1'b1;
         tx_r[0] <= 24'h0;
         tx_r[1] <= 24'h0;
      end else if (clk_en_i) begin
         oe_n_r <= !device_master_i; // R19
         if (fall) begin
            pos_r <= pos_nxt;
            lrclk_r <= adccsp_lr_level(framing_format_sel_i, pos_nxt); // R10 R19
            if (pos_r == `ADCCSP_POS_LAST) begin
               tx_r[0] <= samp_r[0];
               tx_r[1] <= samp_r[1];
            end
            if (adccsp_bit_valid(kidx, sample_width_sel_i)) begin
               serial_sample_out_r <= tx_r[pos_nxt[5]][5'h17 - kidx[4:0]]; // R11 R12 R13 R14 R15
            end else begin
               serial_sample_out_r <= 1'b0; // R20
            end
         end
      end
   end

   assign link.bclk_dev = bclk_r;
   assign link.bclk_dev_oe_n = oe_n_r;
   assign link.lrclk_dev = lrclk_r;
   assign link.lrclk_dev_oe_n = oe_n_r;
   assign link.serial_sample_out = serial_sample_out_r;
endmodule
`default_nettype wire

// ---- rtl/adccsp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adccsp_defs.svh"
module adccsp_host
   import adccsp_pkg::*;
#(
   parameter int BCLK_HALF = 4
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   adccsp_if.host link,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);
   logic [7:0] ctrl_r;
   logic master;
   adccsp_fmt_t fmt;
   adccsp_ww_t ww;
   adccsp_smp_t rx_r [2];
   adccsp_smp_t left_r;
   adccsp_smp_t right_r;
   logic [15:0] frame_cnt_r;
   logic [7:0] hdiv_r;
   logic bclk_r;
   logic lrclk_r;
   logic oe_n_r;
   logic bclk_prev_r;
   logic lr_prev_r;
   logic sync_seen_r;
   logic [5:0] pos_r;
   logic [5:0] pos_nxt;
   logic own_fall;
   logic fall;
   logic rise;
   logic [6:0] kidx;

   assign master = ctrl_r[`ADCCSP_CTRL_MASTER];
   assign fmt = ctrl_r[`ADCCSP_CTRL_FMT_LO +: 2];
   assign ww = ctrl_r[`ADCCSP_CTRL_WW_LO +: 2]; // R16

   // Bus answer one cycle after the request; waitrequest rests high
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
         ctrl_r <= `ADCCSP_CTRL_RESET;
      end else if (clk_en_i) begin
         avs_waitrequest_o <= 1'b1;
         if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            case (avs_address_i)
               `ADCCSP_REG_CTRL: avs_readdata_o <= {24'h0, ctrl_r};
               `ADCCSP_REG_LEFT: avs_readdata_o <= {8'h0, left_r};
               `ADCCSP_REG_RIGHT: avs_readdata_o <= {8'h0, right_r};
               `ADCCSP_REG_STAT: avs_readdata_o <= {16'h0, frame_cnt_r};
               default: avs_readdata_o <= 32'h0;
            endcase
         end
         if (avs_write_i && !avs_waitrequest_o && avs_address_i == `ADCCSP_REG_CTRL &&
             avs_byteenable_i[0]) begin
            ctrl_r <= avs_writedata_i[7:0];
         end
      end
   end

   // As master, bit clock from a divider; data sampled from the shared wire
   assign own_fall = (hdiv_r == 8'(BCLK_HALF - 1)) && bclk_r;
   assign fall = master ? own_fall : (bclk_prev_r && !link.bclk); // R10
   assign rise = !bclk_prev_r && link.bclk;
   assign pos_nxt = (!master && sync_seen_r) ?
                    ((fmt == `ADCCSP_FMT_DSP) ? 6'h00 : 6'h01) : pos_r + 6'h01;
   assign kidx = adccsp_bit_index(fmt, ww, pos_r[4:0]);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hdiv_r <= 8'h0;
         bclk_r <= 1'b0;
         bclk_prev_r <= 1'b0;
         lr_prev_r <= 1'b0;
         sync_seen_r <= 1'b0;
      end else if (clk_en_i) begin
         bclk_prev_r <= link.bclk;
         if (hdiv_r == 8'(BCLK_HALF - 1)) begin
            hdiv_r <= 8'h0;
            bclk_r <= !bclk_r; // R10
         end else begin
            hdiv_r <= hdiv_r + 8'h1;
         end
         if (rise) begin
            lr_prev_r <= link.lrclk;
            sync_seen_r <= adccsp_frame_start(fmt, lr_prev_r, link.lrclk); // R19 R15
         end else if (fall) begin
            sync_seen_r <= 1'b0;
         end
      end
   end

   // Frame tracking, bit capture on rising edges, publish at frame end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pos_r <= `ADCCSP_POS_LAST;
         lrclk_r <= 1'b0;
         oe_n_r <= 1'b1;
         rx_r[0] <= 24'h0;
         rx_r[1] <= 24'h0;
         left_r <= 24'h0;
         right_r <= 24'h0;
         frame_cnt_r <= 16'h0;
      end else if (clk_en_i) begin
         if (!bclk_r) begin
            oe_n_r <= !master; // R19
         end
         if (rise && adccsp_bit_valid(kidx, ww)) begin
            rx_r[pos_r[5]][5'h17 - kidx[4:0]] <= link.serial_sample_out; // R16
         end
         if (fall) begin
            pos_r <= pos_nxt;
            lrclk_r <= adccsp_lr_level(fmt, pos_nxt); // R15 R19
            if (pos_r == `ADCCSP_POS_LAST) begin
               left_r <= rx_r[0];
               right_r <= rx_r[1];
               rx_r[0] <= 24'h0;
               rx_r[1] <= 24'h0;
               frame_cnt_r <= frame_cnt_r + 16'h1;
            end
         end
      end
   end

   assign link.bclk_host = bclk_r;
   assign link.bclk_host_oe_n = oe_n_r;
   assign link.lrclk_host = lrclk_r;
   assign link.lrclk_host_oe_n = oe_n_r;
endmodule
`default_nettype wire

// ---- verif/adccsp_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module adccsp_properties (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic bclk,
   input wire logic lrclk,
   input wire logic serial_sample_out,
   input wire logic bclk_dev_oe_n,
   input wire logic lrclk_dev_oe_n,
   input wire logic bclk_host_oe_n,
   input wire logic lrclk_host_oe_n
);
   logic bclk_r, lr_r, armed_r;
   logic [7:0] nbit_r, nhigh_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Bit rises per frame and per high phase; armed so a partial first frame is not judged
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bclk_r <= 1'b0;
         lr_r <= 1'b0;
         armed_r <= 1'b0;
         nbit_r <= 8'h00;
         nhigh_r <= 8'h00;
      end else begin
         bclk_r <= bclk;
         lr_r <= lrclk;
         if (lrclk && !lr_r) begin
            armed_r <= 1'b1;
            nbit_r <= 8'h00;
            nhigh_r <= 8'h00;
         end else if (bclk && !bclk_r) begin
            nbit_r <= nbit_r + 8'h01;
            nhigh_r <= nhigh_r + {7'h00, lrclk};
         end
      end
   end
   a_data_on_fall: assert property ($changed(serial_sample_out) |-> !bclk)
      else $error("serial data moved while bit clock high");
   a_lr_on_fall: assert property ($changed(lrclk) |-> !bclk)
      else $error("frame clock moved while bit clock high");
   a_frame_bits: assert property (lrclk && !lr_r && armed_r |-> nbit_r == 8'h40)
      else $error("frame is not 64 bit periods");
   a_high_bits: assert property (!lrclk && lr_r && armed_r |-> nhigh_r inside {8'h1, 8'h20})
      else $error("frame clock high phase has wrong length");
   a_bclk_wide: assert property ($rose(bclk) |-> bclk [*2])
      else $error("bit clock high phase too short");
   a_bclk_one_driver: assert property (bclk_dev_oe_n || bclk_host_oe_n)
      else $error("bit clock driven by both ends");
   a_lr_one_driver: assert property (lrclk_dev_oe_n || lrclk_host_oe_n)
      else $error("frame clock driven by both ends");
   a_dev_pins_paired: assert property (bclk_dev_oe_n == lrclk_dev_oe_n)
      else $error("device drives only one clock");
   a_host_pins_paired: assert property (bclk_host_oe_n == lrclk_host_oe_n)
      else $error("controller drives only one clock");
   c_dsp_sync: cover property (!lrclk && lr_r && nhigh_r == 8'h01);
   c_half_frame: cover property (!lrclk && lr_r && nhigh_r == 8'h20);
   c_host_master: cover property (!bclk_host_oe_n && $rose(bclk));
endmodule
`default_nettype wire

// ---- verif/adccsp_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module adccsp_tb;
   logic clk_i = 1'b0, rstn_i = 1'b0, dm = 1'b1, modulator_rate_sel = 1'b0, highpass_enable = 1'b0, mdl = 1'b0, mdr = 1'b0;
   logic rd = 1'b0, wr = 1'b0, lrp = 1'b0, pwr, imck, modck, sval, wq, mq;
   logic [1:0] mcd = 2'h0, fmt = 2'h0, ww = 2'h0;
   logic [2:0] gl = 3'h4, gr = 3'h2;
   logic [3:0] be = 4'hf;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0, rdat, q, sl, sr, mask, s0;
   logic [23:0] lsmp, rsmp, v0, v1;
   logic [63:0] frm = 64'h0, lastf = 64'h0;
   int n_errors = 0, comparisons = 0, pos = 0, nfr = 0, cyc = 0, ni, nm, ns, off, wb, n0;
   adccsp_if lk();
   adccsp_dev #(.HPF_SHIFT(4)) adccsp_dev_i (.clk_i(clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1),
      .link(lk), .device_master_i(dm), .master_clock_divide_sel_i(mcd),
      .modulator_rate_sel_i(modulator_rate_sel), .highpass_enable_i(highpass_enable), .framing_format_sel_i(fmt),
      .sample_width_sel_i(ww), .left_modulator_direct_i(mdl), .right_modulator_direct_i(mdr),
      .gain_left_i(gl), .gain_right_i(gr), .mod_left_i(4'h3), .mod_right_i(4'hd),
      .analog_powered_o(pwr), .internal_master_clock_o(imck), .modulator_clock_o(modck),
      .sample_valid_o(sval), .left_sample_o(lsmp), .right_sample_o(rsmp));
   adccsp_host adccsp_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1), .link(lk),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wq));
   adccsp_properties adccsp_properties_i (.clk_i(clk_i), .rstn_i(rstn_i), .bclk(lk.bclk),
      .lrclk(lk.lrclk), .serial_sample_out(lk.serial_sample_out),
      .bclk_dev_oe_n(lk.bclk_dev_oe_n), .lrclk_dev_oe_n(lk.lrclk_dev_oe_n),
      .bclk_host_oe_n(lk.bclk_host_oe_n), .lrclk_host_oe_n(lk.lrclk_host_oe_n));
   // 50 MHz clock
   always #10 clk_i = !clk_i;
   // Hang guard, well above the roughly 40k cycles the sequence needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         conclude();
      end
   end
   // Own frame decoder on the wire: slot 0 starts at the left edge of the chosen format
   always @(posedge lk.bclk) begin
      if (fmt == 2'h0 ? (lrp && !lk.lrclk) : (fmt == 2'h3 ? lrp : (!lrp && lk.lrclk))) begin
         pos = 0;
      end
      frm[63 - pos] = lk.serial_sample_out;
      if (pos == 63) begin
         lastf = frm;
         nfr++;
      end
      pos = (pos + 1) % 64;
      lrp = lk.lrclk;
   end
   task automatic conclude();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Avalon access: held until waitrequest is seen low, read data taken at that edge
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      do @(posedge clk_i); while (wq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_i);
   endtask
   // Waits k whole frames, then past the controller's publish point
   task automatic sync(input int k);
      n0 = nfr;
      while (nfr < n0 + k) @(posedge clk_i);
      repeat (10) @(posedge clk_i);
   endtask
   task automatic cnt(input int k);
      ni = 0;
      nm = 0;
      ns = 0;
      mq = modck;
      repeat (k) begin
         @(posedge clk_i);
         ni += int'(imck);
         nm += int'(modck && !mq);
         ns += int'(sval);
         mq = modck;
      end
   endtask
   // One link setup from reset, then frame layout checks on the captured wire bits
   task automatic cfg(input logic m, input logic [1:0] f, input logic [1:0] w);
      rstn_i <= 1'b0;
      dm <= m;
      fmt <= f;
      ww <= w;
      repeat (4) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      acc(1'b0, 5'h00, 32'h0, 4'hf);
      `CHK("ctrl_reset", 32'h0, q)
      acc(1'b1, 5'h00, {27'h0, w, f, !m}, 4'hf);
      sync(6);
      wb = (w == 2'h1) ? 20 : ((w == 2'h2) ? 16 : 24);
      off = (f == 2'h0) ? 1 : ((f == 2'h2) ? 32 - wb : 0);
      mask = (32'hffffffff >> (32 - wb)) << (32 - off - wb);
      sl = lastf[63:32];
      sr = lastf[31:0];
      `CHK("pad_left", 32'h0, sl & ~mask)
      `CHK("pad_right", 32'h0, sr & ~mask)
      `CHK("sign_left", 1'b0, sl[31 - off])
      `CHK("sign_right", 1'b1, sr[31 - off])
      if (w == 2'h0) begin
         acc(1'b0, 5'h04, 32'h0, 4'hf);
         `CHK("left", (sl << off) >> 8, q)
         `CHK("gain_l", 32'h180000, q)
         acc(1'b0, 5'h08, 32'h0, 4'hf);
         `CHK("right", (sr << off) >> 8, q)
         `CHK("gain_r", 32'hf40000, q)
      end
   endtask
   initial begin
      for (int i = 0; i < 12; i++) begin
         cfg(!i[2], i[1:0], i[3:2]);
      end
      acc(1'b0, 5'h0c, 32'h0, 4'hf);
      s0 = q;
      sync(2);
      acc(1'b0, 5'h0c, 32'h0, 4'hf);
      `CHK("frames", s0 + 32'h2, q)
      acc(1'b1, 5'h00, 32'h1f, 4'h0);
      acc(1'b0, 5'h00, 32'h0, 4'hf);
      `CHK("ctrl_kept", 32'h16, q)
      acc(1'b1, 5'h10, 32'hff, 4'hf);
      acc(1'b0, 5'h10, 32'h0, 4'hf);
      `CHK("unmapped", 32'h0, q)
      for (int i = 0; i < 3; i++) begin
         mcd <= i[1:0];
         repeat (12) @(posedge clk_i);
         cnt(60);
         `CHK("internal_master_clock", 60 / (i + 1), ni)
      end
      mcd <= 2'h0;
      for (int i = 0; i < 2; i++) begin
         modulator_rate_sel <= i[0];
         repeat (300) @(posedge clk_i);
         cnt(1024);
         `CHK("modulator_clock", 512 >> i, nm)
         `CHK("valid", 4, ns)
      end
      v0 = lsmp;
      `CHK("dc_kept", 1'b1, v0 != 24'h0 && !v0[23])
      highpass_enable <= 1'b1;
      repeat (10240) @(posedge clk_i);
      v1 = lsmp;
      `CHK("dc_removed", 1'b1, (v1[23] ? -v1 : v1) < (v0 >> 2))
      `CHK("powered", 1'b1, pwr)
      mdl <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("one_direct", 1'b1, pwr)
      mdr <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("both_direct", 1'b0, pwr)
      conclude();
   end
endmodule
`default_nettype wire
